//--- inc/ee_consts.svh
// ee_consts.svh: offsets, field positions, reset values and timing counts of the eeprom client
// assumes the reference clock runs at 40 MHz and that the ee_phy and ee_top modules include it
`ifndef EE_CONSTS_SVH
`define EE_CONSTS_SVH

// control byte
`define EE_CTRL_CODE   4'ha
`define EE_CTRL_HI     7
`define EE_CTRL_LO     4
`define EE_CS_HI       3
`define EE_CS_LO       1
`define EE_RW_BIT      0

// array layout
`define EE_PROT_BIT    7
`define EE_ID48_BASE   8'hfa
`define EE_ID64_BASE   8'hf8
`define EE_PAGE_SMALL  8
`define EE_PAGE_LARGE  16
`define EE_BLANK_BYTE  8'hff
`define EE_EXT_RSV0    16'hfffe
`define EE_EXT_RSV1    16'hffff
// arbitrary identifier value, byte at the lowest identifier address is the top byte
`define EE_ID_DEFAULT  64'h0a1b2c3d4e5f6071

// self-timed write cycle
`define EE_TWC_US      5000
`define EE_REF_MHZ     40
`define EE_XING_CYC    8
`define EE_TWC_CYC     ((`EE_TWC_US * `EE_REF_MHZ) - `EE_XING_CYC)

`endif

//--- inc/ee_pkg.sv
// ee_pkg.sv: types of the eeprom client
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package ee_pkg;

    typedef enum logic [6:0] {
        EE_IDLE  = 7'h01,
        EE_CTRL  = 7'h02,
        EE_ADDR  = 7'h04,
        EE_WDATA = 7'h08,
        EE_RACK  = 7'h10,
        EE_RDATA = 7'h20,
        EE_SKIP  = 7'h40
    } ee_state_e;

    typedef struct packed {
        ee_state_e        st;
        logic [7:0]       ptr;
        logic [15:0][7:0] pbuf;
        logic [15:0]      mask;
        logic             ack_en;
        logic             tx_mode;
        logic [7:0]       tx_byte;
        logic             req_tgl;
        logic [1:0]       ack_s;
        logic [2:0]       cs_m;
        logic [2:0]       cs_s;
    } ee_lk_s;

    typedef struct packed {
        logic [1:0]  req_s;
        logic        ack_tgl;
        logic        busy;
        logic [31:0] cnt;
    } ee_rf_s;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic       act;
        logic       oe;
        logic       start_p;
        logic       stop_p;
        logic       rx_valid;
        logic       slot_p;
        logic       slot_ack;
    } ee_phy_s;

endpackage

`default_nettype wire

//--- inc/ee_link_if.sv
// ee_link_if.sv: byte-level events between the bit engine and the protocol logic
// assumes both ends run on the link clock
`timescale 1ns/1ps
`default_nettype none

interface ee_link_if;
    logic       start_p;
    logic       stop_p;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       slot_p;
    logic       slot_ack;
    logic       ack_en;
    logic       tx_mode;
    logic [7:0] tx_byte;

    modport phy (output start_p, stop_p, rx_valid, rx_byte, slot_p, slot_ack,
                 input  ack_en, tx_mode, tx_byte);
    modport proto (input  start_p, stop_p, rx_valid, rx_byte, slot_p, slot_ack,
                   output ack_en, tx_mode, tx_byte);
endinterface

`default_nettype wire

//--- logic/ee_phy.sv
// ee_phy.sv: two-wire bit engine, start/stop detection, byte shift and open-drain drive
// assumes link_clk oversamples scl by a wide margin and lrstn is synchronous to link_clk
`timescale 1ns/1ps
`default_nettype none
`include "ee_consts.svh"

module ee_phy import ee_pkg::*; (
    // clock and reset
    input  wire logic   link_clk,
    input  wire logic   lrstn,
    // pins
    input  wire logic   scl_in,
    input  wire logic   sda_in,
    output logic        sda_out,
    output logic        sda_oe,
    // protocol side
    ee_link_if.phy      lk
);

    ee_phy_s q;
    ee_phy_s d;
    logic    scl_hi;
    logic    rise;
    logic    fall;

    assign scl_hi = q.scl_s[1] & q.scl_s[2];
    assign rise   = q.scl_s[1] & ~q.scl_s[2];
    assign fall   = ~q.scl_s[1] & q.scl_s[2];

    always_comb begin
        d          = q;
        d.scl_s    = {q.scl_s[1:0], scl_in};
        d.sda_s    = {q.sda_s[1:0], sda_in};
        d.start_p  = 1'b0;
        d.stop_p   = 1'b0;
        d.rx_valid = 1'b0;
        d.slot_p   = 1'b0;
        if (scl_hi && q.sda_s[2] && !q.sda_s[1]) begin
            // start or repeated start
            d.start_p = 1'b1;
            d.act     = 1'b1;
            d.cnt     = 4'h0;
            d.oe      = 1'b0;
        end else if (scl_hi && !q.sda_s[2] && q.sda_s[1]) begin
            // stop releases the line
            d.stop_p = 1'b1;
            d.act    = 1'b0;
            d.cnt    = 4'h0;
            d.oe     = 1'b0;
        end else if (q.act && rise) begin
            if (q.cnt == 4'h8) begin
                d.slot_p   = 1'b1;
                d.slot_ack = ~q.sda_s[1];
                d.cnt      = 4'h0;
            end else begin
                d.shift    = {q.shift[6:0], q.sda_s[1]};
                d.cnt      = 4'(q.cnt + 4'h1);
                d.rx_valid = (q.cnt == 4'h7);
            end
        end else if (q.act && fall) begin
            if (q.cnt == 4'h8) begin
                d.oe = lk.ack_en;
            end else begin
                d.oe = lk.tx_mode & ~lk.tx_byte[3'(3'd7 - q.cnt[2:0])];
            end
        end
    end

    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            q <= '{scl_s: 3'h7, sda_s: 3'h7, default: '0};
        end else begin
            q <= d;
        end
    end

    assign sda_out     = 1'b0;
    assign sda_oe      = q.oe;
    assign lk.start_p  = q.start_p;
    assign lk.stop_p   = q.stop_p;
    assign lk.rx_valid = q.rx_valid;
    assign lk.rx_byte  = q.shift;
    assign lk.slot_p   = q.slot_p;
    assign lk.slot_ack = q.slot_ack;

endmodule // ee_phy

`default_nettype wire

//--- logic/ee_top.sv
// ee_top.sv: two-wire serial eeprom client with page buffer, write protection and identifier
// assumes scl/sda come from pins, link_clk is a free-running sampling clock, ref_clk is 40 MHz
//
// Notes on behaviour
// - control code 1010 required before acknowledging
// - cascadable part matches chip-select pins
// - byte after write control loads pointer
// - page buffer holds bytes until stop
// - each data byte bumps low pointer bits
// - upper bits fixed, excess bytes overwrite
// - stop after written data starts cycle
// - page crossing wraps within same page
// - upper half never written, still readable
// - lower half reads and writes normally
// - no acknowledge while write cycle runs
// - read control byte ends in one
// - current read returns last address plus one
// - host nack then stop ends driving
// - repeated start keeps pointer, no write
// - host ack fetches next sequential byte
// - pointer increments after every byte
// - 48-bit identifier at fa to ff
// - 64-bit identifier at f8 to ff
// - extension never starts with fffe/ffff
`timescale 1ns/1ps
`default_nettype none
`include "ee_consts.svh"

module ee_top import ee_pkg::*; #(
    parameter bit          CASCADE   = 1'b0,
    parameter bit          ID64      = 1'b0,
    // arbitrary identifier value
    parameter logic [63:0] ID_BYTES  = `EE_ID_DEFAULT,
    parameter int unsigned WR_CYCLES = `EE_TWC_CYC
) (
    // system
    input  wire logic ref_clk,
    input  wire logic rstn,
    // link
    input  wire logic link_clk,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // chip-select straps
    input  wire logic chip_select_bit0,
    input  wire logic chip_select_bit1,
    input  wire logic chip_select_bit2,
    // status
    output logic      write_busy
);

    localparam int          PAGE    = CASCADE ? `EE_PAGE_LARGE : `EE_PAGE_SMALL;
    localparam logic [7:0]  PM8     = 8'(PAGE - 1);
    localparam logic [7:0]  ID_BASE = ID64 ? `EE_ID64_BASE : `EE_ID48_BASE;
    localparam logic [63:0] ID_W    = ID64 ? ID_BYTES : {ID_BYTES[47:0], 16'h0000};
    localparam logic [31:0] WR_LAST = 32'(WR_CYCLES - 1);

    ee_link_if lk ();

    logic [1:0] rrst_q;
    logic [1:0] lrst_q;
    logic       rrstn;
    logic       lrstn;
    ee_lk_s     lq;
    ee_lk_s     ld;
    ee_rf_s     rq;
    ee_rf_s     rd;
    logic       busy;
    logic       hit;
    logic       commit;
    logic [3:0] idx;
    logic [7:0] mem [0:127];

    // reset release per domain
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rrst_q <= 2'h0;
        end else begin
            rrst_q <= {rrst_q[0], 1'b1};
        end
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end

    assign rrstn = rrst_q[1];
    assign lrstn = lrst_q[1];

    ee_phy u_phy (
        .link_clk (link_clk),
        .lrstn    (lrstn),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .lk       (lk.phy)
    );

    // array read with identifier overlay
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [2:0] k;
        k = 3'(a - ID_BASE);
        if (a >= ID_BASE) begin
            rd_byte = ID_W[8 * (7 - int'(k)) +: 8];
        end else if (a[`EE_PROT_BIT]) begin
            rd_byte = `EE_BLANK_BYTE;
        end else begin
            rd_byte = mem[a[6:0]];
        end
    endfunction

    assign busy = lq.req_tgl != lq.ack_s[1];
    assign idx  = 4'(lq.ptr & PM8);
    assign hit  = (lk.rx_byte[`EE_CTRL_HI:`EE_CTRL_LO] == `EE_CTRL_CODE)
                  && (!CASCADE || lk.rx_byte[`EE_CS_HI:`EE_CS_LO] == lq.cs_s)
                  && !busy;

    // protocol on the link clock
    always_comb begin
        ld       = lq;
        ld.cs_m  = {chip_select_bit2, chip_select_bit1, chip_select_bit0};
        ld.cs_s  = lq.cs_m;
        ld.ack_s = {lq.ack_s[0], rq.ack_tgl};
        commit   = 1'b0;
        if (lk.start_p) begin
            ld.st      = EE_CTRL;
            ld.mask    = '0;
            ld.ack_en  = 1'b0;
            ld.tx_mode = 1'b0;
        end else if (lk.stop_p) begin
            if (lq.st == EE_WDATA && lq.mask != '0) begin
                ld.req_tgl = ~lq.req_tgl;
                commit     = ~lq.ptr[`EE_PROT_BIT];
            end
            ld.st      = EE_IDLE;
            ld.mask    = '0;
            ld.ack_en  = 1'b0;
            ld.tx_mode = 1'b0;
        end else if (lk.slot_p) begin
            ld.ack_en = 1'b0;
            case (lq.st)
                EE_RACK: begin
                    ld.st = EE_RDATA;
                end
                EE_RDATA: begin
                    ld.ptr = 8'(lq.ptr + 8'h01);
                    if (lk.slot_ack) begin
                        ld.tx_byte = rd_byte(8'(lq.ptr + 8'h01));
                    end else begin
                        ld.tx_mode = 1'b0;
                        ld.st      = EE_SKIP;
                    end
                end
                default: begin
                end
            endcase
        end else if (lk.rx_valid) begin
            case (lq.st)
                EE_CTRL: begin
                    if (hit) begin
                        ld.ack_en = 1'b1;
                        if (lk.rx_byte[`EE_RW_BIT]) begin
                            ld.st      = EE_RACK;
                            ld.tx_mode = 1'b1;
                            ld.tx_byte = rd_byte(lq.ptr);
                        end else begin
                            ld.st = EE_ADDR;
                        end
                    end else begin
                        ld.st = EE_SKIP;
                    end
                end
                EE_ADDR: begin
                    ld.ptr    = lk.rx_byte;
                    ld.ack_en = 1'b1;
                    ld.st     = EE_WDATA;
                end
                EE_WDATA: begin
                    ld.pbuf[idx] = lk.rx_byte;
                    ld.mask[idx] = 1'b1;
                    ld.ptr       = (lq.ptr & ~PM8) | (8'(lq.ptr + 8'h01) & PM8);
                    ld.ack_en    = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            lq <= '{st: EE_IDLE, default: '0};
        end else begin
            lq <= ld;
        end
    end

    // page commit into the writable half
    always_ff @(posedge link_clk) begin
        if (commit) begin
            for (int i = 0; i < PAGE; i++) begin
                if (lq.mask[i]) begin
                    mem[7'(lq.ptr & ~PM8) | 7'(i)] <= lq.pbuf[i];
                end
            end
        end
    end

    assign lk.ack_en  = lq.ack_en;
    assign lk.tx_mode = lq.tx_mode;
    assign lk.tx_byte = lq.tx_byte;

    // write-cycle timer on the reference clock
    always_comb begin
        rd       = rq;
        rd.req_s = {rq.req_s[0], lq.req_tgl};
        if (rq.req_s[1] != rq.ack_tgl) begin
            if (rq.cnt == WR_LAST) begin
                rd.ack_tgl = rq.req_s[1];
                rd.cnt     = 32'h0000_0000;
            end else begin
                rd.cnt = 32'(rq.cnt + 32'h0000_0001);
            end
        end
        rd.busy = rq.req_s[1] != rd.ack_tgl;
    end

    always_ff @(posedge ref_clk or negedge rrstn) begin
        if (!rrstn) begin
            rq <= '0;
        end else begin
            rq <= rd;
        end
    end

    assign write_busy = rq.busy;

    // checks
    ctrl_code_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.rx_valid && lq.st == EE_CTRL && lk.rx_byte[7:4] != `EE_CTRL_CODE
        |=> !lq.ack_en && lq.st == EE_SKIP)
        else $error("wrong control code acknowledged");

    cs_match_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        CASCADE && lk.rx_valid && lq.st == EE_CTRL && lk.rx_byte[3:1] != lq.cs_s
        |=> lq.st == EE_SKIP)
        else $error("chip select mismatch accepted");

    addr_load_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.rx_valid && lq.st == EE_ADDR |=> lq.ptr == $past(lk.rx_byte) && lq.st == EE_WDATA)
        else $error("word address not loaded");

    page_wrap_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.rx_valid && lq.st == EE_WDATA
        |=> (lq.ptr & ~PM8) == ($past(lq.ptr) & ~PM8)
            && (lq.ptr & PM8) == (8'($past(lq.ptr) + 8'h01) & PM8))
        else $error("page pointer left its page");

    ack_busy_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.rx_valid && lq.st == EE_CTRL && busy |=> !lq.ack_en ##1 !lq.ack_en)
        else $error("acknowledge given during write cycle");

    stop_cycle_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.stop_p && lq.st == EE_WDATA && lq.mask != '0
        |=> lq.req_tgl != $past(lq.req_tgl) ##[1:4] busy)
        else $error("stop did not start write cycle");

    protect_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        commit |-> !lq.ptr[`EE_PROT_BIT] && lk.stop_p)
        else $error("write reached protected half");

    rnd_read_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.start_p && (lq.st == EE_ADDR || lq.st == EE_WDATA)
        |=> lq.req_tgl == $past(lq.req_tgl) && lq.ptr == $past(lq.ptr) && lq.mask == '0)
        else $error("repeated start disturbed pointer or wrote");

    rd_seq_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.slot_p && lk.slot_ack && lq.st == EE_RDATA
        |=> lq.ptr == 8'($past(lq.ptr) + 8'h01) && lq.tx_mode && lq.tx_byte == rd_byte(lq.ptr))
        else $error("sequential read did not advance");

    rd_end_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.slot_p && !lk.slot_ack && lq.st == EE_RDATA |=> !lq.tx_mode && lq.st == EE_SKIP)
        else $error("read continued after host nack");

    ptr_wrap_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        lk.slot_p && lq.st == EE_RDATA && lq.ptr == 8'hff |=> lq.ptr == 8'h00)
        else $error("pointer did not wrap to zero");

    wr_bound_a: assert property (@(posedge ref_clk) disable iff (!rrstn)
        rq.busy |-> rq.cnt <= WR_LAST)
        else $error("write cycle ran past its bound");

    id_rsv_a: assert property (@(posedge link_clk) disable iff (!lrstn)
        ID64 |-> ID_BYTES[39:24] != `EE_EXT_RSV0 && ID_BYTES[39:24] != `EE_EXT_RSV1)
        else $error("identifier extension uses reserved value");

    page_commit_c: cover property (@(posedge link_clk) disable iff (!lrstn)
        commit && lq.mask == 16'(2 ** PAGE - 1));

    seq_read_c: cover property (@(posedge link_clk) disable iff (!lrstn)
        lk.slot_p && lk.slot_ack && lq.st == EE_RDATA);

    rnd_read_c: cover property (@(posedge link_clk) disable iff (!lrstn)
        lk.start_p && lq.st == EE_WDATA && lq.mask == '0);

    poll_nack_c: cover property (@(posedge link_clk) disable iff (!lrstn)
        lk.rx_valid && lq.st == EE_CTRL && busy);

endmodule // ee_top

`default_nettype wire

//--- dv/ee_host.sv
// ee_host.sv: behavioural two-wire bus host driving scl and pulling sda
// assumes a pull-up resolves sda from all pull enables outside this module
`timescale 1ns/1ps
`default_nettype none

module ee_host (
    // timing
    input  wire logic link_clk,
    // wires
    input  wire logic sda_w,
    output logic      scl,
    output logic      pull
);
    // bus not busy: both lines high
    initial begin
        scl  = 1'b1;
        pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge link_clk);
    endtask

    // start and repeated start
    task automatic start();
        pull = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(5);
        pull = 1'b1;
        tick(5);
        scl = 1'b0;
    endtask

    task automatic stop();
        pull = 1'b1;
        tick(5);
        scl = 1'b1;
        tick(5);
        pull = 1'b0;
        tick(10);
    endtask

    // data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        tick(5);
        pull = ~b;
        tick(5);
        scl = 1'b1;
        tick(5);
        r = sda_w;
        tick(5);
        scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // ack high pulls sda low and asks for the next byte, ack low ends the read
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(~ack, r);
    endtask
endmodule // ee_host

`default_nettype wire

//--- dv/serial_eeprom_access_tb.sv
// serial_eeprom_access_tb.sv: eeprom client against a host model and an array model
// assumes ee_top with an 8-byte page and the 48-bit identifier
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_access_tb;
    localparam int WRC = 2000;
    // arbitrary identifier value
    localparam logic [63:0] IDV = 64'h13579bdf2468ace0;

    logic       ref_clk;
    logic       link_clk;
    logic       rstn;
    logic [2:0] cs;
    logic       scl;
    logic       pull;
    logic       sda_oe;
    logic       sda_out;
    logic       busy;
    wire logic  sda_w = ~(pull | (sda_oe & ~sda_out));
    int         mem[256];
    int         ptr;
    int         fails;
    int         checked;
    logic [47:0] id48;
    logic [63:0] e64;

    ee_top #(.WR_CYCLES(WRC), .ID_BYTES(IDV)) i_ee_top (
        .ref_clk(ref_clk), .rstn(rstn), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
        .chip_select_bit2(cs[2]), .write_busy(busy));

    ee_host i_ee_host (.link_clk(link_clk), .sda_w(sda_w), .scl(scl), .pull(pull));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // chip-select bits are random, this variant ignores them
    task automatic ctrl(input logic rd, output logic ack);
        i_ee_host.start();
        i_ee_host.send_byte({4'ha, 3'($urandom), rd}, ack);
    endtask

    task automatic poll();
        logic ack;
        int   n;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        check(8'(busy), 8'h01);
        ctrl(1'b0, ack);
        i_ee_host.stop();
        check(8'(ack), 8'h00);
        n = 0;
        do begin
            ctrl(1'b0, ack);
            i_ee_host.stop();
            n++;
        end while (ack !== 1'b1 && n < 8);
        check(8'(ack), 8'h01);
        check(8'(busy), 8'h00);
    endtask

    task automatic wr_page(input int a, input int n);
        logic       ack;
        logic [7:0] d;
        int         w;
        ctrl(1'b0, ack);
        check(8'(ack), 8'h01);
        i_ee_host.send_byte(8'(a), ack);
        check(8'(ack), 8'h01);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            i_ee_host.send_byte(d, ack);
            check(8'(ack), 8'h01);
            w = (a & 248) | ((a + i) & 7);
            if (w < 128) begin
                mem[w] = int'(d);
            end
        end
        ptr = (a & 248) | ((a + n) & 7);
        i_ee_host.stop();
        poll();
    endtask

    // a negative address means a current-address read
    task automatic rd(input int a, input int n);
        logic       ack;
        logic [7:0] d;
        if (a >= 0) begin
            ctrl(1'b0, ack);
            i_ee_host.send_byte(8'(a), ack);
            ptr = a;
        end
        ctrl(1'b1, ack);
        check(8'(ack), 8'h01);
        for (int i = 0; i < n; i++) begin
            i_ee_host.recv_byte(i < n - 1, d);
            check(d, 8'(mem[ptr]));
            id48 = {id48[39:0], d};
            ptr = (ptr + 1) & 255;
        end
        i_ee_host.stop();
        check(8'(sda_oe), 8'h00);
        check(8'(sda_out), 8'h00);
        check(8'(busy), 8'h00);
    endtask

    initial begin
        logic ack;
        rstn = 1'b0;
        cs = 3'h0;
        fails = 0;
        checked = 0;
        void'($urandom(32'hf078c179));
        for (int a = 0; a < 256; a++) begin
            mem[a] = (a >= 128) ? 255 : 0;
        end
        for (int i = 0; i < 6; i++) begin
            mem[250 + i] = int'(IDV[47 - 8 * i -: 8]);
        end
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (10) @(negedge link_clk);
        cs = 3'($urandom);
        wr_page(5, 10);
        wr_page(8, 8);
        $display("test page_write done");
        rd(0, 16);
        $display("test random_read done");
        wr_page(252, 8);
        rd(248, 10);
        rd(-1, 1);
        rd(250, 6);
        e64 = {id48[47:24], 16'hfffe, id48[23:0]};
        for (int i = 0; i < 8; i++) begin
            check(e64[63 - 8 * i -: 8], (i == 3) ? 8'hff : (i == 4) ? 8'hfe : IDV[47 - 8 * (i < 3 ? i : i - 2) -: 8]);
        end
        $display("test protect_id_read done");
        for (int c = 0; c < 16; c++) begin
            if (c != 10) begin
                i_ee_host.start();
                i_ee_host.send_byte({4'(c), 3'($urandom), 1'b0}, ack);
                i_ee_host.stop();
                check(8'(ack), 8'h00);
            end
        end
        $display("test control_code done");
        print_verdict();
    end

    initial begin
        #2ms;
        fails++;
        print_verdict();
    end
endmodule // serial_eeprom_access_tb

`default_nettype wire
